/* File: hw/cod_clk_ctrl.v */
// clock pin control: clock-output divider, external clock pin select, oscillator enables
// assumes an apb master on core_clk_i and synchronous pin inputs
// status reads sample the pin mux input in the setup cycle
//
// Summary of operation
// - clock output runs at system clock divided by one, two or four, field bits 1:0.
// - after reset the clock output runs at system clock divided by four.
// - divider field value 3 stops the clock output entirely.
// - divided clock reaches its shared pin only while the pin mux selects it.
// - select bit picks one of two pins for external clock; default jtag-clock pin.
// - bit 14 of source control turns the crystal oscillator off.
// - bit 13 of source control blocks the external clock input path.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps

module cod_clk_ctrl (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output wire [31:0] prdata_o,
    output wire pslverr_o,
    // clock pins
    input wire shared_pin_clkout_func_i,
    output wire clock_output_pin_o,
    output wire clock_output_pin_oe_o,
    input wire shared_pin_jtag_clock_i,
    input wire shared_pin_alt_clock_i,
    output wire external_oscillator_input_o,
    // oscillator controls
    output wire crystal_osc_enable_o,
    output wire ext_clock_path_enable_o
);

`include "cod_clk_regs.vh"

// ----------------------------------------
// registers
// ----------------------------------------
localparam [31:0] OUT_CTRL_RST = `COD_OUT_CTRL_RST;
localparam [31:0] SRC_CTRL_RST = `COD_SRC_CTRL_RST;

// the two off bits are stored as disables so that reset leaves both sources on
reg [1:0] div_q;
reg [1:0] div_d;
reg insel_q;
reg insel_d;
reg pinmux_q;
reg pinmux_d;
reg clock_output_control_reg_off_q;
reg clock_output_control_reg_off_d;
reg xtal_off_q;
reg xtal_off_d;
reg [31:0] rdata_q;
reg [31:0] rdata_d;
reg err_q;
reg err_d;

wire [31:0] out_ctrl_w;
wire [31:0] src_ctrl_w;
wire [31:0] status_w;
wire div_running;
wire clk_div;
wire wr_en;
wire rd_en;
wire setup_en;
wire out_ctrl_sel;
wire src_ctrl_sel;
wire ext_pin_clk;
wire ext_path_on;

// one decoder for the write selects and the read error, so they never disagree on a hit
function addr_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
        addr_hit = (addr == ofs);
    end
endfunction

function is_mapped;
    input [11:0] addr;
    begin
        is_mapped = addr_hit(addr, `COD_CLK_OUT_CTRL_OFS) || addr_hit(addr, `COD_CLK_SRC_CTRL_OFS) ||
                    addr_hit(addr, `COD_CLK_STATUS_OFS);
    end
endfunction

// single-cycle access phase: pready is high whenever penable is
assign setup_en = psel_i & ~penable_i;
assign wr_en = psel_i & penable_i & pwrite_i;
assign rd_en = setup_en & ~pwrite_i;
assign out_ctrl_sel = addr_hit(paddr_i, `COD_CLK_OUT_CTRL_OFS);
assign src_ctrl_sel = addr_hit(paddr_i, `COD_CLK_SRC_CTRL_OFS);

assign out_ctrl_w = {23'h000000, pinmux_q, 1'b0, insel_q, 4'h0, div_q};
assign src_ctrl_w = {17'h00000, xtal_off_q, clock_output_control_reg_off_q, 13'h0000};
assign status_w = {29'h00000000, shared_pin_clkout_func_i, div_running, clock_output_pin_oe_o};

// ----------------------------------------
// control register writes
// ----------------------------------------
// a write lands only at the access edge; lanes without a strobe keep their bits
always @* begin
    div_d = div_q;
    insel_d = insel_q;
    pinmux_d = pinmux_q;
    clock_output_control_reg_off_d = clock_output_control_reg_off_q;
    xtal_off_d = xtal_off_q;
    // lane 0: divider field and external pin select
    if (wr_en & out_ctrl_sel & pstrb_i[0]) begin
        div_d = pwdata_i[`COD_DIV_MSB:`COD_DIV_LSB];
        insel_d = pwdata_i[`COD_INSEL_BIT];
    end
    // lane 1: local pin mux bit
    if (wr_en & out_ctrl_sel & pstrb_i[1]) begin
        pinmux_d = pwdata_i[`COD_PINMUX_BIT];
    end
    // lane 1 of source control: path-off and crystal-off bits
    if (wr_en & src_ctrl_sel & pstrb_i[1]) begin
        clock_output_control_reg_off_d = pwdata_i[`COD_XCLKPATH_OFF_BIT];
        xtal_off_d = pwdata_i[`COD_XTAL_OFF_BIT];
    end
end

always @(posedge core_clk_i) begin
    if (rst_i) begin
        div_q <= OUT_CTRL_RST[`COD_DIV_MSB:`COD_DIV_LSB];
        insel_q <= OUT_CTRL_RST[`COD_INSEL_BIT];
        pinmux_q <= OUT_CTRL_RST[`COD_PINMUX_BIT];
        clock_output_control_reg_off_q <= SRC_CTRL_RST[`COD_XCLKPATH_OFF_BIT];
        xtal_off_q <= SRC_CTRL_RST[`COD_XTAL_OFF_BIT];
    end else begin
        div_q <= div_d;
        insel_q <= insel_d;
        pinmux_q <= pinmux_d;
        clock_output_control_reg_off_q <= clock_output_control_reg_off_d;
        xtal_off_q <= xtal_off_d;
    end
end

// ----------------------------------------
// read data and error, captured in the setup cycle
// ----------------------------------------
// capturing at setup gives registered read data that already stands in the access phase
always @* begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup_en) begin
        // a write's setup clears read data so stale values never stand
        err_d = ~is_mapped(paddr_i);
        rdata_d = 32'h00000000;
        if (rd_en) begin
            case (paddr_i)
                `COD_CLK_OUT_CTRL_OFS: begin
                    rdata_d = out_ctrl_w;
                end
                `COD_CLK_SRC_CTRL_OFS: begin
                    rdata_d = src_ctrl_w;
                end
                `COD_CLK_STATUS_OFS: begin
                    rdata_d = status_w;
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end
end

always @(posedge core_clk_i) begin
    if (rst_i) begin
        rdata_q <= 32'h00000000;
        err_q <= 1'b0;
    end else begin
        rdata_q <= rdata_d;
        err_q <= err_d;
    end
end

assign pready_o = 1'b1;
assign prdata_o = rdata_q;
assign pslverr_o = psel_i & penable_i & err_q;

// ----------------------------------------
// clock output divider and pin gating
// ----------------------------------------
cod_clk_divider u_div (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .div_sel_i(div_q),
    .clk_div_o(clk_div),
    .running_o(div_running)
);

// the pin mux is an input from the gpio block or the local mux bit
// divide by one passes the core clock through this gate: the pin carries a clock, not data
assign clock_output_pin_oe_o = shared_pin_clkout_func_i | pinmux_q;
assign clock_output_pin_o = clock_output_pin_oe_o & clk_div;

// ----------------------------------------
// external clock source selection
// ----------------------------------------
// software must set the path-off bit during debug; hardware does not watch the jtag port
assign ext_pin_clk = insel_q ? shared_pin_jtag_clock_i : shared_pin_alt_clock_i;
assign ext_path_on = ~clock_output_control_reg_off_q;

// pin chosen first and gated last, so a blocked path stays low whatever the pins do
assign external_oscillator_input_o = ext_path_on & ext_pin_clk;
assign ext_clock_path_enable_o = ext_path_on;
assign crystal_osc_enable_o = ~xtal_off_q;

endmodule

/* File: hw/cod_clk_divider.v */
// divider that makes the clock-output waveform from the system clock
// assumes div_sel_i is a registered field; changes take effect at the next core clock edge, in any phase
`timescale 1ns/1ps

module cod_clk_divider (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // control
    input wire [1:0] div_sel_i,
    // divided clock and state
    output wire clk_div_o,
    output wire running_o
);

`include "cod_clk_regs.vh"

// ----------------------------------------
// phase counter
// ----------------------------------------
reg [1:0] cnt_q;
reg [1:0] cnt_d;
reg out_q;
reg out_d;

// divide by one cannot be made with a flop; the core clock is passed through for it
always @* begin
    cnt_d = cnt_q + 2'h1;
    out_d = out_q;
    case (div_sel_i)
        `COD_DIV_BY4: begin
            out_d = ~cnt_q[1];
        end
        `COD_DIV_BY2: begin
            out_d = ~out_q;
        end
        `COD_DIV_BY1: begin
            out_d = 1'b0;
        end
        default: begin
            cnt_d = 2'h0;
            out_d = 1'b0;
        end
    endcase
end

always @(posedge core_clk_i) begin
    if (rst_i) begin
        cnt_q <= 2'h0;
        out_q <= 1'b0;
    end else begin
        cnt_q <= cnt_d;
        out_q <= out_d;
    end
end

assign clk_div_o = (div_sel_i == `COD_DIV_BY1) ? core_clk_i : out_q;
assign running_o = (div_sel_i != `COD_DIV_OFF);

endmodule

/* File: hw/cod_clk_regs.vh */
// register offsets, field positions and reset values for the clock pin control block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef COD_CLK_REGS_VH
`define COD_CLK_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define COD_CLK_OUT_CTRL_OFS 12'h000
`define COD_CLK_SRC_CTRL_OFS 12'h004
`define COD_CLK_STATUS_OFS 12'h008

// ----------------------------------------
// clock-output control fields
// ----------------------------------------
`define COD_DIV_LSB 0
`define COD_DIV_MSB 1
`define COD_INSEL_BIT 6
`define COD_PINMUX_BIT 8

// ----------------------------------------
// clock source control fields
// ----------------------------------------
`define COD_XCLKPATH_OFF_BIT 13
`define COD_XTAL_OFF_BIT 14

// ----------------------------------------
// divider encodings
// ----------------------------------------
`define COD_DIV_BY4 2'h0
`define COD_DIV_BY2 2'h1
`define COD_DIV_BY1 2'h2
`define COD_DIV_OFF 2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define COD_OUT_CTRL_RST 32'h00000040
`define COD_SRC_CTRL_RST 32'h00000000

`endif

/* File: test/cod_clk_ctrl_chk.sv */
// port checker for the clock pin control block
// assumes bind onto cod_clk_ctrl, one clock
`timescale 1ns/1ps
module cod_clk_ctrl_chk (
    input wire core_clk_i, rst_i, psel_i, penable_i, pwrite_i, shared_pin_clkout_func_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire clock_output_pin_o, clock_output_pin_oe_o,
    input wire external_oscillator_input_o, crystal_osc_enable_o, ext_clock_path_enable_o
);
    wire wr = psel_i && penable_i && pwrite_i;
    wire po = clock_output_pin_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_pin_gated: assert property (!clock_output_pin_oe_o |-> !po)
        else $error("pin not gated");
    a_oe_mux: assert property (shared_pin_clkout_func_i |-> clock_output_pin_oe_o)
        else $error("pin enable low");
    a_xtal_off: assert property (wr && paddr_i == 12'h004 |=> crystal_osc_enable_o == !$past(pwdata_i[14]))
        else $error("crystal enable");
    a_path_off: assert property (wr && paddr_i == 12'h004 |=> ext_clock_path_enable_o == !$past(pwdata_i[13]))
        else $error("path enable");
    a_path_blocks: assert property ((!ext_clock_path_enable_o)[*4] |-> !external_oscillator_input_o)
        else $error("path leaks");
    a_div_off: assert property (wr && paddr_i == 12'h000 && pwdata_i[1:0] == 2'h3 |-> ##6 (!po)[*4])
        else $error("clock not off");
    a_div_half: assert property (wr && paddr_i == 12'h000 && pwdata_i[8] && pwdata_i[1:0] == 2'h1
        |-> ##6 (po != $past(po))[*4])
        else $error("not half rate");
    a_rst_quarter: assert property ($fell(rst_i) && shared_pin_clkout_func_i
        |-> ##6 (po == $past(po, 4) && po != $past(po, 2))[*4])
        else $error("not quarter rate");
endmodule
bind cod_clk_ctrl cod_clk_ctrl_chk u_chk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .shared_pin_clkout_func_i(shared_pin_clkout_func_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .clock_output_pin_o(clock_output_pin_o),
    .clock_output_pin_oe_o(clock_output_pin_oe_o),
    .external_oscillator_input_o(external_oscillator_input_o),
    .crystal_osc_enable_o(crystal_osc_enable_o),
    .ext_clock_path_enable_o(ext_clock_path_enable_o)
);

/* File: test/cod_osc_model.sv */
// board oscillators on the two candidate external clock pins
// assumes free-running sources, unrelated to the core clock
`timescale 1ns/1ps
module cod_osc_model (
    input wire dbg_i,
    output wire jtag_clk_o,
    output wire alt_clk_o
);
    logic osc_a = 1'b0;
    logic osc_b = 1'b0;
    always #100 osc_a = ~osc_a;
    always #140 osc_b = ~osc_b;
    // debug takes the clock off the shared pin, its pull-up wins
    assign jtag_clk_o = dbg_i ? 1'b1 : osc_a;
    assign alt_clk_o = osc_b;
endmodule

/* File: test/tb_top.sv */
// random and corner-case bench for the clock pin control block
// assumes the apb slave answers with pready; oscillator model on the clock pins
`timescale 1ns/1ps
`include "cod_clk_regs.vh"
module tb_top;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, mux = 1, dbg = 0, err;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, rd, d;
    wire prdy, perr, pin, oe, jtag, alt, ext, xen, xpe;
    wire [31:0] prd;
    integer bad_count = 0, check_count = 0, cyc = 0, seed = 32'h7dee, i, pin_chg = 0, n0;
    logic [31:0] r;
    // every change of the clock output pin, counted over a window of core cycles
    always @(pin) pin_chg++;
    always #2 clk = ~clk;
    cod_osc_model u_osc (.dbg_i(dbg), .jtag_clk_o(jtag), .alt_clk_o(alt));
    cod_clk_ctrl u_dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hF), .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
        .shared_pin_clkout_func_i(mux), .clock_output_pin_o(pin), .clock_output_pin_oe_o(oe),
        .shared_pin_jtag_clock_i(jtag), .shared_pin_alt_clock_i(alt), .external_oscillator_input_o(ext),
        .crystal_osc_enable_o(xen), .ext_clock_path_enable_o(xpe));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // pin changes in eight core cycles for each divider code
    function automatic integer exp_chg(input logic [1:0] dv);
        case (dv)
            `COD_DIV_BY4: exp_chg = 4;
            `COD_DIV_BY2: exp_chg = 8;
            `COD_DIV_BY1: exp_chg = 16;
            default: exp_chg = 0;
        endcase
    endfunction
    // status word: bit2 pin mux input, bit1 divider running, bit0 pin enable
    function automatic logic [31:0] exp_status(input logic m, input logic [31:0] c);
        exp_status = {29'h0, m, c[1:0] != `COD_DIV_OFF, m | c[8]};
    endfunction
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // pins move asynchronously: compare a few cycles after each edge
    task automatic follow(input logic use_jtag);
        repeat (2) begin
            if (use_jtag) @(jtag);
            else @(alt);
            repeat (3) @(posedge clk);
            chk(ext, use_jtag ? jtag : alt);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, `COD_CLK_OUT_CTRL_OFS, 0);
        chk(rd, `COD_OUT_CTRL_RST);
        follow(1);
        apb(0, `COD_CLK_SRC_CTRL_OFS, 0);
        chk(rd, `COD_SRC_CTRL_RST);
        for (i = 0; i < 8; i++) begin
            d = ($random(seed) & 32'h00000040) | 32'h00000100 | i[1:0];
            r = $random(seed);
            mux <= r[0];
            apb(1, `COD_CLK_OUT_CTRL_OFS, d);
            repeat (2) @(posedge clk);
            #1 n0 = pin_chg;
            repeat (8) @(posedge clk);
            #1 chk(pin_chg - n0, exp_chg(d[1:0]));
            @(posedge clk);
            apb(0, `COD_CLK_OUT_CTRL_OFS, 0);
            chk(rd, d);
            apb(0, `COD_CLK_STATUS_OFS, 0);
            chk(rd, exp_status(mux, d));
            chk(oe, 1'b1);
            if (i[1:0] == 2'h3) chk(pin, 1'b0);
            d = $random(seed) & 32'h00006000;
            apb(1, `COD_CLK_SRC_CTRL_OFS, d);
            apb(0, `COD_CLK_SRC_CTRL_OFS, 0);
            chk(rd, d);
            chk(xen, !d[14]);
            chk(xpe, !d[13]);
        end
        mux <= 1'b0;
        apb(1, `COD_CLK_OUT_CTRL_OFS, 0);
        chk(oe, 1'b0);
        apb(1, `COD_CLK_SRC_CTRL_OFS, 0);
        follow(0);
        apb(1, `COD_CLK_OUT_CTRL_OFS, 32'h00000040);
        follow(1);
        apb(1, `COD_CLK_SRC_CTRL_OFS, 32'h00002000);
        dbg <= 1'b1;
        repeat (30) @(posedge clk);
        chk(ext, 1'b0);
        apb(0, 12'h00C, 0);
        chk(err, 1'b1);
        chk(rd, 0);
        give_verdict;
    end
endmodule
